// file: core/l3_l4_key_field_extract.sv
// layer 3/4 lookup key field extractor with registered key outputs
// Notes on behaviour
// R1: class 0 when more-fragments flag and offset are both zero.
// R2: class 1 when more-fragments set and offset zero: initial fragment.
// R3: class 2 when offset nonzero and not above the threshold.
// R4: class 3 when offset is above the threshold: follow-up fragment.
// R5: offset threshold is a software input, loaded before it is relied on.
// R6: short-length flag when layer 4 length is below configured minimum.
// R7: options flag when ipv4 header length exceeds five; options unparsed.
// R8: dscp key is frame dscp, or classified dscp when selected.
// R9: destination key is ipv4 destination or ipv6 destination low bits.
// R10: llc frames: source key is control byte then payload bytes 0..2.
// R11: snap frames: source key is pid bytes 2..0 then payload byte 0.
// R12: ipv4 frames: source key is the full source ipv4 address.
// R13: ipv6 source low bits; other ethertype frames payload bytes 0..3.
// R14: destination swap puts destination ip into source key of ip frames.
// R15: protocol key is ipv4 protocol or ipv6 next header.
// R16: tcp-or-udp flag for ip frames with protocol six or seventeen.
// R17: tcp-or-udp flag forced to one for oam y.1731 frames.
// R18: tcp flag when ipv4 protocol or ipv6 next header is six.
// R19: ethertype-coded flag when ethertype is at least 0x600.
// R20: snap flag on length-coded frames whose llc header is aa-aa-03.
// R21: ipv4 flag when ethertype is 0x800 and version is four.
// R22: destination swap makes source-type fields carry destination info; the code swaps only the source key of ip frames.
// R23: non-ipv4 frames get zero fragment class, short and options flags.
`timescale 1ns/1ps
module l3_l4_key_field_extract
  import l3l4_key_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  // parsed frame, one frame per cycle while frame_valid is high
  input  wire logic                frame_valid,
  input  wire logic [ETYPE_W-1:0]  ethertype,
  input  wire logic [IP_VER_W-1:0] ip_version,
  input  wire logic [BYTE_W-1:0]   llc_dsap,
  input  wire logic [BYTE_W-1:0]   llc_ssap,
  input  wire logic [BYTE_W-1:0]   llc_ctrl,
  input  wire logic [PID_W-1:0]    snap_pid,
  input  wire logic [ADDR_W-1:0]   payload_bytes,
  input  wire logic                more_fragments_bit,
  input  wire logic [FO_W-1:0]     frag_offset_value,
  input  wire logic [IHL_W-1:0]    ip_hdr_len,
  input  wire logic [L4_LEN_W-1:0] l4_len,
  input  wire logic [DSCP_W-1:0]   frame_dscp,
  input  wire logic [DSCP_W-1:0]   classified_dscp,
  input  wire logic [ADDR_W-1:0]   frame_dest_ip,
  input  wire logic [ADDR_W-1:0]   frame_src_ip,
  input  wire logic [PROTO_W-1:0]  frame_proto,
  input  wire logic                oam_y1731_frame,
  // configuration
  input  wire logic [FO_W-1:0]     frag_ofs_limit,
  input  wire logic [L4_LEN_W-1:0] min_transport_len,
  input  wire logic                classified_dscp_select,
  input  wire logic                dest_swap_select,
  // key fields, valid the cycle after frame_valid
  output logic                     key_valid,
  output frag_class_t              frag_class_key,
  output logic                     short_l4_len_flag,
  output logic                     ip_hdr_opts_flag,
  output logic [DSCP_W-1:0]        dscp_key_field,
  output logic [ADDR_W-1:0]        dest_ip_low32,
  output logic [ADDR_W-1:0]        src_ip_low32,
  output logic [PROTO_W-1:0]       ip_proto_key,
  output logic                     tcp_or_udp_flag,
  output logic                     tcp_only_flag,
  output logic                     ethertype_coded_flag,
  output logic                     ip_or_llc_snap_flag,
  output logic                     ipv4_frame_flag
);
  frame_class_if cls ();

  frag_class_t                     frag_class_next;
  logic                            short_len_next;
  logic                            hdr_opts_next;
  logic                            is_ip;
  logic [ADDR_W-1:0]               src_key_next;
  logic [ADDR_W-1:0]               dest_key_next;
  logic [PROTO_W-1:0]              proto_next;
  logic [DSCP_W-1:0]               dscp_next;
  logic                            tcp_or_udp_flag_next;
  logic                            tcp_next;

  // returns byte n of a byte vector, byte 0 in the low bits
  function automatic logic [BYTE_W-1:0] byte_of(
    input logic [PID_W-1:0] vec,
    input int               idx
  );
    byte_of = vec[idx*BYTE_W +: BYTE_W];
  endfunction

  frame_type_decode u_decode (
    .ethertype  (ethertype),
    .ip_version (ip_version),
    .llc_dsap   (llc_dsap),
    .llc_ssap   (llc_ssap),
    .llc_ctrl   (llc_ctrl),
    .cls        (cls.dec)
  );

  frag_classify u_frag (
    .cls                (cls.use_side),
    .more_fragments_bit (more_fragments_bit),
    .frag_offset_value  (frag_offset_value),
    .frag_ofs_limit     (frag_ofs_limit),
    .ip_hdr_len         (ip_hdr_len),
    .l4_len             (l4_len),
    .min_transport_len  (min_transport_len),
    .frag_class         (frag_class_next),
    .short_len          (short_len_next),
    .hdr_opts           (hdr_opts_next)
  );

  assign is_ip = cls.ipv4 || cls.ipv6;

  // source key overloading by frame type; payload byte 0 lands high only on other ethertype frames
  always_comb begin
    src_key_next = ADDR_RST;
    if (!cls.ethertype_coded && !cls.ip_or_snap) begin
      src_key_next = {llc_ctrl,
                      byte_of({8'h00, payload_bytes}, BYTE_0),
                      byte_of({8'h00, payload_bytes}, BYTE_1),
                      byte_of({8'h00, payload_bytes}, BYTE_2)}; // [R10]
    end else if (!cls.ethertype_coded) begin
      src_key_next = {byte_of(snap_pid, BYTE_2),
                      byte_of(snap_pid, BYTE_1),
                      byte_of(snap_pid, BYTE_0),
                      byte_of({8'h00, payload_bytes}, BYTE_0)}; // [R11]
    end else if (is_ip) begin
      // swap wins over source info for ip frames only
      src_key_next = dest_swap_select ? frame_dest_ip // [R14] [R22]
                                      : frame_src_ip; // [R12] [R13]
    end else begin
      src_key_next = {byte_of({8'h00, payload_bytes}, BYTE_0),
                      byte_of({8'h00, payload_bytes}, BYTE_1),
                      byte_of({8'h00, payload_bytes}, BYTE_2),
                      byte_of({8'h00, payload_bytes}, BYTE_3)}; // [R13]
    end
  end

  // destination key holds the low word for both ip versions
  assign dest_key_next = is_ip ? frame_dest_ip : ADDR_RST; // [R9]

  // protocol and transport flags; oam overloads the tcp-or-udp flag
  assign proto_next   = is_ip ? frame_proto : PROTO_RST; // [R15]
  assign tcp_next     = is_ip && (frame_proto == PROTO_TCP); // [R18]
  assign tcp_or_udp_flag_next = (is_ip && ((frame_proto == PROTO_TCP) ||
                                   (frame_proto == PROTO_UDP))) // [R16]
                        || oam_y1731_frame; // [R17]

  // dscp source select is sampled with the frame, not later
  assign dscp_next = classified_dscp_select ? classified_dscp // [R8]
                                            : frame_dscp;

  // key strobe: one cycle per accepted frame
  always_ff @(posedge clk) begin
    if (rst) begin
      key_valid <= 1'b0;
    end else begin
      key_valid <= frame_valid;
    end
  end

  // layer 3 flag group; fields hold between frames
  always_ff @(posedge clk) begin
    if (rst) begin
      frag_class_key    <= FRAG_NONE;
      short_l4_len_flag <= 1'b0;
      ip_hdr_opts_flag  <= 1'b0;
      dscp_key_field    <= DSCP_RST;
    end else if (frame_valid) begin
      frag_class_key    <= frag_class_next;
      short_l4_len_flag <= short_len_next;
      ip_hdr_opts_flag  <= hdr_opts_next;
      dscp_key_field    <= dscp_next;
    end
  end

  // address group
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_ip_low32 <= ADDR_RST;
      src_ip_low32  <= ADDR_RST;
    end else if (frame_valid) begin
      dest_ip_low32 <= dest_key_next;
      src_ip_low32  <= src_key_next;
    end
  end

  // protocol and frame type group
  always_ff @(posedge clk) begin
    if (rst) begin
      ip_proto_key         <= PROTO_RST;
      tcp_or_udp_flag      <= 1'b0;
      tcp_only_flag        <= 1'b0;
      ethertype_coded_flag <= 1'b0;
      ip_or_llc_snap_flag  <= 1'b0;
      ipv4_frame_flag      <= 1'b0;
    end else if (frame_valid) begin
      ip_proto_key         <= proto_next;
      tcp_or_udp_flag      <= tcp_or_udp_flag_next;
      tcp_only_flag        <= tcp_next;
      ethertype_coded_flag <= cls.ethertype_coded;
      ip_or_llc_snap_flag  <= cls.ip_or_snap;
      ipv4_frame_flag      <= cls.ipv4;
    end
  end

  // checks tie the key fields except ipv4_frame_flag and ip_or_llc_snap_flag to the frame seen one cycle before

  property p_frag_none;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4 && !more_fragments_bit &&
      (frag_offset_value == FO_ZERO)
      |=> (frag_class_key == FRAG_NONE);
  endproperty
  a_frag_none: assert property (p_frag_none) // [R1]
    else $error("unfragmented ipv4 frame not class 0");

  property p_frag_initial;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4 && more_fragments_bit &&
      (frag_offset_value == FO_ZERO)
      |=> (frag_class_key == FRAG_INITIAL);
  endproperty
  a_frag_initial: assert property (p_frag_initial) // [R2]
    else $error("initial fragment not class 1");

  property p_frag_suspect;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4 && (frag_offset_value != FO_ZERO) &&
      (frag_offset_value <= frag_ofs_limit)
      |=> (frag_class_key == FRAG_SUSPECT);
  endproperty
  a_frag_suspect: assert property (p_frag_suspect) // [R3]
    else $error("small offset fragment not class 2");

  property p_frag_follow;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4 && (frag_offset_value > frag_ofs_limit)
      |=> (frag_class_key == FRAG_FOLLOW);
  endproperty
  a_frag_follow: assert property (p_frag_follow) // [R4]
    else $error("large offset fragment not class 3");

  property p_short_len;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4
      |=> (short_l4_len_flag ==
           ($past(l4_len) < $past(min_transport_len)));
  endproperty
  a_short_len: assert property (p_short_len) // [R6]
    else $error("short transport length flag wrong");

  property p_opts;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4
      |=> (ip_hdr_opts_flag == ($past(ip_hdr_len) > IHL_NO_OPTS));
  endproperty
  a_opts: assert property (p_opts) // [R7]
    else $error("header options flag wrong");

  property p_dscp;
    @(posedge clk) disable iff (rst)
      frame_valid |=> (dscp_key_field ==
        ($past(classified_dscp_select) ? $past(classified_dscp)
                                       : $past(frame_dscp)));
  endproperty
  a_dscp: assert property (p_dscp) // [R8]
    else $error("dscp key source wrong");

  property p_swap;
    @(posedge clk) disable iff (rst)
      frame_valid && is_ip && dest_swap_select
      |=> (src_ip_low32 == dest_ip_low32);
  endproperty
  a_swap: assert property (p_swap) // [R14]
    else $error("swapped source key does not match destination");

  property p_ipv4_src;
    @(posedge clk) disable iff (rst)
      frame_valid && cls.ipv4 && !dest_swap_select
      |=> (src_ip_low32 == $past(frame_src_ip));
  endproperty
  a_ipv4_src: assert property (p_ipv4_src) // [R12]
    else $error("ipv4 source key wrong");

  property p_snap_src;
    @(posedge clk) disable iff (rst)
      frame_valid && !cls.ethertype_coded && cls.ip_or_snap
      |=> (src_ip_low32[BYTE_W-1:0] == $past(payload_bytes[BYTE_W-1:0]));
  endproperty
  a_snap_src: assert property (p_snap_src) // [R11]
    else $error("snap source key low byte wrong");

  property p_oam_tcp_or_udp_flag;
    @(posedge clk) disable iff (rst)
      frame_valid && oam_y1731_frame |=> tcp_or_udp_flag;
  endproperty
  a_oam_tcp_or_udp_flag: assert property (p_oam_tcp_or_udp_flag) // [R17]
    else $error("oam frame without tcp-or-udp flag");

  property p_tcp;
    @(posedge clk) disable iff (rst)
      frame_valid |=> (tcp_only_flag ==
        ($past(is_ip) && ($past(frame_proto) == PROTO_TCP)));
  endproperty
  a_tcp: assert property (p_tcp) // [R18]
    else $error("tcp flag wrong");

  property p_non_ipv4_zero;
    @(posedge clk) disable iff (rst)
      frame_valid && !cls.ipv4
      |=> (frag_class_key == FRAG_NONE) && !short_l4_len_flag &&
          !ip_hdr_opts_flag;
  endproperty
  a_non_ipv4_zero: assert property (p_non_ipv4_zero) // [R23]
    else $error("non-ipv4 frame has fragment flags");

  // non-ip frames must not leak a stale address into the lookup key
  property p_dest_key;
    @(posedge clk) disable iff (rst)
      frame_valid |=> (dest_ip_low32 ==
        ($past(is_ip) ? $past(frame_dest_ip) : ADDR_RST));
  endproperty
  a_dest_key: assert property (p_dest_key) // [R9]
    else $error("destination key wrong");

  property p_proto_key;
    @(posedge clk) disable iff (rst)
      frame_valid |=> (ip_proto_key ==
        ($past(is_ip) ? $past(frame_proto) : PROTO_RST));
  endproperty
  a_proto_key: assert property (p_proto_key) // [R15]
    else $error("protocol key wrong");

  property p_tcp_or_udp_flag;
    @(posedge clk) disable iff (rst)
      frame_valid && is_ip &&
      ((frame_proto == PROTO_TCP) || (frame_proto == PROTO_UDP))
      |=> tcp_or_udp_flag;
  endproperty
  a_tcp_or_udp_flag: assert property (p_tcp_or_udp_flag) // [R16]
    else $error("tcp or udp frame without tcp-or-udp flag");

  // the boundary value itself already counts as ethertype coded
  property p_etype_flag;
    @(posedge clk) disable iff (rst)
      frame_valid |=> (ethertype_coded_flag ==
        ($past(ethertype) >= ETYPE_MIN_CODED));
  endproperty
  a_etype_flag: assert property (p_etype_flag) // [R19]
    else $error("ethertype coded flag wrong");
endmodule

// file: core/l3l4_key_pkg.sv
// constants and types shared by the layer 3/4 key field extractor
package l3l4_key_pkg;
  localparam int          BYTE_W          = 8;
  localparam int          ETYPE_W         = 16;
  localparam int          IP_VER_W        = 4;
  localparam int          FO_W            = 13;
  localparam int          IHL_W           = 4;
  localparam int          L4_LEN_W        = 16;
  localparam int          DSCP_W          = 6;
  localparam int          ADDR_W          = 32;
  localparam int          PROTO_W         = 8;
  localparam int          PID_W           = 40;
  localparam int          FRAG_CLASS_W    = 2;
  // byte positions inside the byte vectors (byte n sits at bits 8n+7:8n)
  localparam int          BYTE_0          = 0;
  localparam int          BYTE_1          = 1;
  localparam int          BYTE_2          = 2;
  localparam int          BYTE_3          = 3;
  // frame type decoding
  localparam logic [15:0] ETYPE_MIN_CODED = 16'h0600;
  localparam logic [15:0] ETYPE_IPV4      = 16'h0800;
  localparam logic [15:0] ETYPE_IPV6      = 16'h86DD;
  localparam logic [3:0]  IP_VER_4        = 4'h4;
  localparam logic [3:0]  IP_VER_6        = 4'h6;
  localparam logic [7:0]  SNAP_DSAP       = 8'hAA;
  localparam logic [7:0]  SNAP_SSAP       = 8'hAA;
  localparam logic [7:0]  SNAP_CTRL       = 8'h03;
  // header limits and protocol numbers
  localparam logic [3:0]  IHL_NO_OPTS     = 4'h5;
  localparam logic [12:0] FO_ZERO         = 13'h0000;
  localparam logic [7:0]  PROTO_TCP       = 8'h06;
  localparam logic [7:0]  PROTO_UDP       = 8'h11;
  // reset values of the key fields
  localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
  localparam logic [7:0]  PROTO_RST       = 8'h00;
  localparam logic [5:0]  DSCP_RST        = 6'h00;

  typedef enum logic [1:0] {
    FRAG_NONE    = 2'h0,
    FRAG_INITIAL = 2'h1,
    FRAG_SUSPECT = 2'h2,
    FRAG_FOLLOW  = 2'h3
  } frag_class_t;
endpackage

// file: core/frame_class_if.sv
// frame type flags passed from the decoder to the key builder
`timescale 1ns/1ps
interface frame_class_if;
  logic ethertype_coded;
  logic ip_or_snap;
  logic ipv4;
  logic ipv6;

  modport dec (output ethertype_coded, output ip_or_snap,
               output ipv4, output ipv6);
  modport use_side (input ethertype_coded, input ip_or_snap,
                    input ipv4, input ipv6);
endinterface

// file: core/frame_type_decode.sv
// combinational frame type decoder: ethertype, ip_or_llc_snap_flag, ipv4, ipv6 flags
`timescale 1ns/1ps
module frame_type_decode
  import l3l4_key_pkg::*;
(
  input  wire logic [ETYPE_W-1:0]  ethertype,
  input  wire logic [IP_VER_W-1:0] ip_version,
  input  wire logic [BYTE_W-1:0]   llc_dsap,
  input  wire logic [BYTE_W-1:0]   llc_ssap,
  input  wire logic [BYTE_W-1:0]   llc_ctrl,
  frame_class_if.dec               cls
);
  logic is_v4;
  logic is_v6;
  logic is_snap;

  // ethertype at or above the length limit means ethertype coding
  assign cls.ethertype_coded = (ethertype >= ETYPE_MIN_CODED); // [R19]

  // ipv4 needs both the ethertype and the version nibble to agree
  assign is_v4 = cls.ethertype_coded && (ethertype == ETYPE_IPV4) &&
                 (ip_version == IP_VER_4); // [R21]
  assign is_v6 = cls.ethertype_coded && (ethertype == ETYPE_IPV6) &&
                 (ip_version == IP_VER_6);

  // snap header only counts on length-coded frames
  assign is_snap = !cls.ethertype_coded && (llc_dsap == SNAP_DSAP) &&
                   (llc_ssap == SNAP_SSAP) &&
                   (llc_ctrl == SNAP_CTRL); // [R20]

  assign cls.ipv4       = is_v4;
  assign cls.ipv6       = is_v6;
  assign cls.ip_or_snap = is_v4 || is_v6 || is_snap;
endmodule

// file: core/frag_classify.sv
// combinational ipv4 fragmentation class, short length and options flags
`timescale 1ns/1ps
module frag_classify
  import l3l4_key_pkg::*;
(
  frame_class_if.use_side          cls,
  input  wire logic                more_fragments_bit,
  input  wire logic [FO_W-1:0]     frag_offset_value,
  input  wire logic [FO_W-1:0]     frag_ofs_limit,
  input  wire logic [IHL_W-1:0]    ip_hdr_len,
  input  wire logic [L4_LEN_W-1:0] l4_len,
  input  wire logic [L4_LEN_W-1:0] min_transport_len,
  output frag_class_t              frag_class,
  output logic                     short_len,
  output logic                     hdr_opts
);
  // non-ipv4 frames get all-zero flags so lookups stay deterministic
  always_comb begin
    frag_class = FRAG_NONE; // [R23]
    if (cls.ipv4) begin
      if (frag_offset_value == FO_ZERO) begin
        frag_class = more_fragments_bit ? FRAG_INITIAL // [R2]
                                        : FRAG_NONE;   // [R1]
      end else if (frag_offset_value <= frag_ofs_limit) begin
        frag_class = FRAG_SUSPECT; // [R3] [R5]
      end else begin
        frag_class = FRAG_FOLLOW; // [R4] [R5]
      end
    end
  end

  // option bytes are never walked, only the header length is checked
  assign short_len = cls.ipv4 && (l4_len < min_transport_len); // [R6]
  assign hdr_opts  = cls.ipv4 && (ip_hdr_len > IHL_NO_OPTS);    // [R7]
endmodule

// file: sim/key_lookup_sink.sv
// lookup engine stand-in that takes every key the extractor offers
`timescale 1ns/1ps
module key_lookup_sink
  import l3l4_key_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              key_valid,
  input  wire logic [ADDR_W-1:0] dest_ip_low32,
  input  wire logic [ADDR_W-1:0] src_ip_low32,
  output logic [31:0]            keys_taken,
  output logic [ADDR_W-1:0]      last_lookup
);
  // never stalls: the extractor has no back-pressure, so neither do we
  always_ff @(posedge clk) begin
    if (rst) begin
      keys_taken  <= 32'h0000_0000;
      last_lookup <= 32'h0000_0000;
    end else if (key_valid) begin
      keys_taken  <= keys_taken + 32'h0000_0001;
      last_lookup <= dest_ip_low32 ^ src_ip_low32; // stand-in hash
    end
  end
endmodule

// file: sim/l3_l4_key_field_extract_test.sv
// self-checking bench with reference model for the layer 3/4 key extractor
`timescale 1ns/1ps
module l3_l4_key_field_extract_test;
  import l3l4_key_pkg::*;
  typedef struct packed {
    logic [1:0]  frag;
    logic        sh;
    logic        op;
    logic [5:0]  dscp;
    logic [31:0] dst;
    logic [31:0] src;
    logic [7:0]  proto;
    logic        tu;
    logic        tcp;
    logic        etc;
    logic        snap;
    logic        v4;
  } key_t;
  logic        clk, rst, frame_valid, more_fragments_bit, oam_y1731_frame;
  logic        classified_dscp_select, dest_swap_select, started;
  logic [15:0] ethertype, l4_len, min_transport_len;
  logic [3:0]  ip_version, ip_hdr_len;
  logic [7:0]  llc_dsap, llc_ssap, llc_ctrl, frame_proto, ip_proto_key;
  logic [39:0] snap_pid;
  logic [31:0] payload_bytes, frame_dest_ip, frame_src_ip, keys_taken;
  logic [12:0] frag_offset_value, frag_ofs_limit;
  logic [5:0]  frame_dscp, classified_dscp, dscp_key_field;
  logic        key_valid, short_l4_len_flag, ip_hdr_opts_flag;
  logic        tcp_or_udp_flag, tcp_only_flag, ethertype_coded_flag;
  logic        ip_or_llc_snap_flag, ipv4_frame_flag;
  frag_class_t frag_class_key;
  logic [31:0] dest_ip_low32, src_ip_low32;
  int          errors, total_checks, pops;
  key_t        exp_q[$];
  key_t        last;

  l3_l4_key_field_extract dut (.clk, .rst, .frame_valid, .ethertype,
    .ip_version, .llc_dsap, .llc_ssap, .llc_ctrl, .snap_pid, .payload_bytes,
    .more_fragments_bit, .frag_offset_value, .ip_hdr_len, .l4_len,
    .frame_dscp, .classified_dscp, .frame_dest_ip, .frame_src_ip,
    .frame_proto, .oam_y1731_frame, .frag_ofs_limit, .min_transport_len,
    .classified_dscp_select, .dest_swap_select, .key_valid, .frag_class_key,
    .short_l4_len_flag, .ip_hdr_opts_flag, .dscp_key_field, .dest_ip_low32,
    .src_ip_low32, .ip_proto_key, .tcp_or_udp_flag, .tcp_only_flag,
    .ethertype_coded_flag, .ip_or_llc_snap_flag, .ipv4_frame_flag);

  key_lookup_sink sink (.clk, .rst, .key_valid, .dest_ip_low32,
    .src_ip_low32, .keys_taken, .last_lookup());

  always #4 clk = ~clk;

  // reference key worked out from the current frame inputs
  function automatic key_t model();
    key_t k;
    logic ip;
    k      = '0;
    k.etc  = ethertype >= 16'h0600;
    k.v4   = ethertype == 16'h0800 && ip_version == 4'h4;
    ip     = k.v4 || (ethertype == 16'h86DD && ip_version == 4'h6);
    k.snap = k.etc ? ip : {llc_dsap, llc_ssap, llc_ctrl} == 24'hAA_AA03;
    if (k.v4 && frag_offset_value == 13'h0000)
      k.frag = {1'b0, more_fragments_bit};
    else if (k.v4)
      k.frag = (frag_offset_value <= frag_ofs_limit) ? 2'h2 : 2'h3;
    k.sh    = k.v4 && l4_len < min_transport_len;
    k.op    = k.v4 && ip_hdr_len > 4'h5;
    k.dscp  = classified_dscp_select ? classified_dscp : frame_dscp;
    k.dst   = ip ? frame_dest_ip : 32'h0000_0000;
    k.proto = ip ? frame_proto : 8'h00;
    k.tcp   = ip && frame_proto == 8'h06;
    k.tu    = k.tcp || (ip && frame_proto == 8'h11) || oam_y1731_frame;
    if (ip)
      k.src = dest_swap_select ? frame_dest_ip : frame_src_ip;
    else if (k.etc)
      k.src = {<<8{payload_bytes}};
    else if (k.snap)
      k.src = {snap_pid[23:0], payload_bytes[7:0]};
    else
      k.src = {llc_ctrl, payload_bytes[7:0], payload_bytes[15:8],
               payload_bytes[23:16]};
    return k;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // random frame biased toward type, offset, length and protocol edges
  task automatic drive(input bit valid);
    logic [15:0] et_tab [6] = '{16'h0800, 16'h86DD, 16'h0600, 16'h05FF,
                                16'h0801, 16'h0000};
    int          pick;
    frame_valid = valid;
    pick = $urandom_range(0, 6);
    ethertype = pick == 6 ? 16'($urandom) : et_tab[pick];
    ip_version = $urandom_range(0, 3) == 0 ? 4'($urandom) :
                 (ethertype == 16'h86DD ? 4'h6 : 4'h4);
    {llc_dsap, llc_ssap, llc_ctrl} = $urandom_range(0, 1) ? 24'hAA_AA03 :
                                     24'($urandom);
    snap_pid = {8'($urandom), $urandom};
    payload_bytes = $urandom;
    frame_dest_ip = $urandom;
    frame_src_ip = $urandom;
    more_fragments_bit = 1'($urandom);
    frag_ofs_limit = 13'($urandom);
    pick = $urandom_range(0, 3);
    frag_offset_value = pick == 0 ? 13'h0000 : pick == 1 ? frag_ofs_limit :
                        pick == 2 ? frag_ofs_limit + 13'h0001 : 13'($urandom);
    ip_hdr_len = 4'($urandom);
    min_transport_len = 16'($urandom);
    l4_len = min_transport_len + 16'($urandom_range(0, 2)) - 16'h0001;
    frame_dscp = 6'($urandom);
    classified_dscp = 6'($urandom);
    classified_dscp_select = 1'($urandom);
    dest_swap_select = 1'($urandom);
    pick = $urandom_range(0, 2);
    frame_proto = pick == 0 ? 8'h06 : pick == 1 ? 8'h11 : 8'($urandom);
    oam_y1731_frame = $urandom_range(0, 5) == 0;
  endtask

  // the queue stays in step with what the design takes at each edge
  always @(posedge clk) begin
    if (rst) begin
      exp_q.delete();
      last = '0;
      pops = 0;
      started <= 1'b1;
    end else if (frame_valid)
      exp_q.push_back(model());
  end

  // outputs must show the newest key, or hold it while no key arrives
  always @(negedge clk) begin
    if (started) begin
      check(key_valid, exp_q.size() != 0);
      if (exp_q.size() != 0) begin
        last = exp_q.pop_front();
        pops++;
      end
      check(frag_class_key, last.frag);
      check(short_l4_len_flag, last.sh);
      check(ip_hdr_opts_flag, last.op);
      check(dscp_key_field, last.dscp);
      check(dest_ip_low32, last.dst);
      check(src_ip_low32, last.src);
      check(ip_proto_key, last.proto);
      check(tcp_or_udp_flag, last.tu);
      check(tcp_only_flag, last.tcp);
      check(ethertype_coded_flag, last.etc);
      check(ip_or_llc_snap_flag, last.snap);
      check(ipv4_frame_flag, last.v4);
    end
  end

  // cut a hang short well past the expected run of about 4500 cycles
  initial begin
    #200_000;
    errors++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    started = 1'b0;
    errors = 0;
    total_checks = 0;
    pops = 0;
    last = '0;
    void'($urandom(32'h46EA_8BC6));
    drive(1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    $display("test reset done");
    // 0: back to back, 1: sparse, 2: sparse with a reset in mid-stream
    for (int t = 0; t < 3; t++) begin
      for (int i = 0; i < 1500; i++) begin
        @(negedge clk);
        drive(t == 0 || $urandom_range(0, 2) != 0);
        rst = t == 2 && i >= 700 && i < 702;
      end
      $display("test %0d done", t);
    end
    @(negedge clk);
    drive(1'b0);
    repeat (3) @(negedge clk);
    check(keys_taken, pops);
    test_done();
  end
endmodule
